/* File: dic_pkg.sv */
// package for the digital input conditioner: register map, field layout, timing
package dic_pkg;
   // ***********************************************************
   // terminals, functions, timing
   // ***********************************************************
   localparam int           NUM_TERM        = 9;
   localparam int           NUM_SLOW        = 7;
   localparam int           NUM_FUNC        = 38;
   localparam logic [5:0]   FUNC_MAX        = 6'h25;
   localparam logic [5:0]   FUNC_NONE       = 6'h00;
   localparam logic [5:0]   FUNC_SERVO_ON   = 6'h01;
   localparam logic [2:0]   LOGIC_MAX       = 3'h4;
   localparam logic [2:0]   LOGIC_LOW       = 3'h0;
   localparam logic [2:0]   LOGIC_HIGH      = 3'h1;
   localparam logic [2:0]   LOGIC_RISE      = 3'h2;
   localparam logic [2:0]   LOGIC_FALL      = 3'h3;
   localparam logic [2:0]   LOGIC_BOTH      = 3'h4;
   localparam int           CLK_PERIOD_NS   = 40;
   localparam int           SLOW_FILT_NS    = 3000000;
   localparam int           FAST_FILT_NS    = 250000;
   localparam int           SLOW_FILT_CYC   = (SLOW_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           FAST_FILT_CYC   = (FAST_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int           CNT_W           = 17;
   // ***********************************************************
   // register map (byte addresses)
   // ***********************************************************
   localparam logic [7:0]   REG_CFG_LAST    = 8'h44;
   localparam logic [7:0]   REG_STATUS      = 8'h48;
   localparam logic [7:0]   REG_MASK        = 8'h4c;
   localparam logic [7:0]   REG_INPUTS      = 8'h50;
   localparam logic [7:0]   REG_FUNC_LO     = 8'h54;
   localparam logic [7:0]   REG_FUNC_HI     = 8'h58;
   localparam int           ST_DUP_BIT      = 0;
   localparam int           ST_REPOWER_BIT  = 1;
   localparam int           ST_W            = 2;
   // ***********************************************************
   // per terminal configuration
   // ***********************************************************
   typedef struct packed {
      logic [5:0] func;
      logic [2:0] lsel;
   } dic_term_cfg_t;
   typedef logic [5:0] dic_func_arr_t [NUM_TERM];
   localparam dic_func_arr_t FUNC_RST = '{6'h0e, 6'h0f, 6'h0d, 6'h02, 6'h01,
                                          6'h0c, 6'h03, 6'h00, 6'h00};
endpackage

/* File: dic_term_model.sv */
// partner model: switches or host controller driving the nine input terminals
module dic_term_model
   import dic_pkg::*;
#(
   parameter int SLOW_CYC = 8,
   parameter int FAST_CYC = 3
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                cmd_go,
   input  wire logic [3:0]          cmd_idx,
   input  wire logic                cmd_lvl,
   input  wire logic                cmd_pulse,
   input  wire logic [7:0]          cmd_len,
   output logic                     busy,
   output logic      [NUM_TERM-1:0] term
);
   logic [7:0] cnt_r;
   logic [3:0] idx_r;
   logic       ret_r;

   // levels held past filter time
   // a held level outlasts its filter by one cycle, so a zero servo on delay is covered;
   // only an explicit pulse command is shorter and then returns to the old level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         term  <= '0;
         cnt_r <= 8'h00;
         idx_r <= 4'h0;
         ret_r <= 1'b0;
         busy  <= 1'b0;
      end else if (cmd_go && !busy) begin
         term[cmd_idx] <= cmd_lvl;
         idx_r         <= cmd_idx;
         ret_r         <= cmd_pulse;
         busy          <= 1'b1;
         cnt_r         <= cmd_pulse ? cmd_len :
                          8'((cmd_idx < NUM_SLOW) ? SLOW_CYC + 1 : FAST_CYC + 1);
      end else if (busy) begin
         cnt_r <= cnt_r - 8'h01;
         if (cnt_r == 8'h01) begin
            busy <= 1'b0;
            if (ret_r) begin
               term[idx_r] <= ~term[idx_r];
            end
         end
      end
   end
endmodule

/* File: dic_top.sv */
// digital input conditioner: filters, validity logic, function mapping, apb registers

// Function
// - two terminals carrying the same function raise the duplicate allocation fault.
// - removing the function of an asserted terminal leaves that function latched active.
// - terminals one to seven accept only levels held longer than 3 ms.
// - terminals eight and nine accept only levels held longer than 0.25 ms.
// - pulses shorter than the filter time never reach the conditioned signal.
// - logic select 0 to 4 picks low level, high level, rising, falling or both edges.
// - terminal nine always drives the position change on fly switch.
// - servo on must sit on a terminal and defaults to terminal five with code 1.
// - moving servo on raises the repower fault and servo on then follows the virtual input.
// - function codes run 0 to 37 with 0 meaning no function.
module dic_top
   import dic_pkg::*;
#(
   parameter int SLOW_CYC = SLOW_FILT_CYC,
   parameter int FAST_CYC = FAST_FILT_CYC
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [NUM_TERM-1:0] input_terminal,
   input  wire logic                drive_running,
   input  wire logic                virtual_input,
   output logic      [NUM_FUNC-1:0] func_active,
   output logic                     servo_on,
   output logic                     pos_change_switch,
   output logic                     duplicate_allocation_fault,
   output logic                     repower_required_fault,
   output logic                     irq
);
   // ***********************************************************
   // declarations
   // ***********************************************************
   dic_term_cfg_t             cfg_r [NUM_TERM];
   logic [NUM_TERM-1:0]       filt_r;
   logic [NUM_TERM-1:0]       prev_r;
   logic [CNT_W-1:0]          cnt_r [NUM_TERM];
   logic [NUM_TERM-1:0]       term_valid;
   logic [NUM_FUNC-1:0]       latch_r;
   logic [NUM_FUNC-1:0]       alloc;
   logic [NUM_FUNC-1:0]       latch_set;
   logic [NUM_FUNC-1:0]       func_nxt;
   logic [ST_W-1:0]           status_r;
   logic [ST_W-1:0]           mask_r;
   logic [ST_W-1:0]           st_set;
   logic                      moved_r;
   logic                      dup;
   logic                      wr_acc;
   logic                      rd_setup;
   logic                      addr_ok;
   logic                      cfg_hit;
   logic [3:0]                cfg_idx;
   logic                      cfg_is_logic;
   logic                      cfg_wr;
   logic [5:0]                old_func;
   logic [31:0]               rd_nxt;
   logic                      servo_move;

   // ***********************************************************
   // apb decode
   // ***********************************************************
   assign wr_acc       = psel & penable & pwrite;
   assign rd_setup     = psel & ~penable & ~pwrite;
   assign cfg_hit      = (paddr <= REG_CFG_LAST) && (paddr[1:0] == 2'b00);
   assign cfg_idx      = paddr[6:3];
   assign cfg_is_logic = paddr[2];
   assign old_func     = cfg_r[cfg_idx].func;
   // zero wait states: the access cycle is the only wait
   assign pready       = 1'b1;
   assign cfg_wr       = wr_acc & cfg_hit & ~drive_running;

   always_comb begin
      if (cfg_hit) begin
         addr_ok = 1'b1;
      end else if (paddr == REG_STATUS || paddr == REG_MASK) begin
         addr_ok = 1'b1;
      end else if (paddr == REG_INPUTS || paddr == REG_FUNC_LO || paddr == REG_FUNC_HI) begin
         addr_ok = 1'b1;
      end else begin
         addr_ok = 1'b0;
      end
   end
   assign pslverr = psel & penable & ~addr_ok;

   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (cfg_hit) begin
         if (cfg_is_logic) begin
            rd_nxt[2:0] = cfg_r[cfg_idx].lsel;
         end else begin
            rd_nxt[5:0] = cfg_r[cfg_idx].func;
         end
      end else if (paddr == REG_STATUS) begin
         rd_nxt[ST_W-1:0] = status_r;
      end else if (paddr == REG_MASK) begin
         rd_nxt[ST_W-1:0] = mask_r;
      end else if (paddr == REG_INPUTS) begin
         rd_nxt[NUM_TERM-1:0] = filt_r;
      end else if (paddr == REG_FUNC_LO) begin
         rd_nxt = func_active[31:0];
      end else if (paddr == REG_FUNC_HI) begin
         rd_nxt[NUM_FUNC-33:0] = func_active[NUM_FUNC-1:32];
      end
   end

   // read data is captured in the setup cycle so the access cycle needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_nxt;
      end
   end

   // ***********************************************************
   // configuration registers
   // ***********************************************************
   // servo on default
   // terminal five carries servo on after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int t = 0; t < NUM_TERM; t++) begin
            cfg_r[t].func <= FUNC_RST[t];
            cfg_r[t].lsel <= LOGIC_LOW;
         end
      end else if (cfg_wr && cfg_idx < 4'(NUM_TERM)) begin
         // range checks
         // out of range values are dropped without an error response
         if (cfg_is_logic) begin
            if (pwdata[15:0] <= 16'(LOGIC_MAX)) begin
               cfg_r[cfg_idx].lsel <= pwdata[2:0];
            end
         end else if (pwdata[15:0] <= 16'(FUNC_MAX)) begin
            cfg_r[cfg_idx].func <= pwdata[5:0];
         end
      end
   end

   // ***********************************************************
   // input filters
   // ***********************************************************
   // a new level is taken only after it has been stable for the whole window,
   // so any shorter glitch restarts the count and never shows
   for (genvar g = 0; g < NUM_TERM; g++) begin : g_filt
      localparam int LIM = (g < NUM_SLOW) ? SLOW_CYC : FAST_CYC;
      // stable count
      // the window is counted in clocks, so a slower pclk needs a smaller count
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_r[g]  <= '0;
            filt_r[g] <= 1'b0;
         end else if (input_terminal[g] == filt_r[g]) begin
            cnt_r[g] <= '0;
         end else if (cnt_r[g] == CNT_W'(LIM - 1)) begin
            cnt_r[g]  <= '0;
            filt_r[g] <= input_terminal[g];
         end else begin
            cnt_r[g] <= cnt_r[g] + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_r <= '0;
      end else begin
         prev_r <= filt_r;
      end
   end

   // ***********************************************************
   // validity logic
   // ***********************************************************
   always_comb begin
      for (int t = 0; t < NUM_TERM; t++) begin
         // level or pulse
         // codes 5 to 7 cannot be written, so the default arm only sees both edges
         case (cfg_r[t].lsel)
            LOGIC_LOW:  term_valid[t] = ~filt_r[t];
            LOGIC_HIGH: term_valid[t] = filt_r[t];
            LOGIC_RISE: term_valid[t] = filt_r[t] & ~prev_r[t];
            LOGIC_FALL: term_valid[t] = ~filt_r[t] & prev_r[t];
            default:    term_valid[t] = filt_r[t] ^ prev_r[t];
         endcase
      end
   end

   // forced edge valid
   // level settings on terminal nine fall back to rising
   always_comb begin
      if (cfg_r[NUM_TERM-1].lsel < LOGIC_RISE) begin
         pos_change_switch = filt_r[NUM_TERM-1] & ~prev_r[NUM_TERM-1];
      end else begin
         pos_change_switch = term_valid[NUM_TERM-1];
      end
   end

   // ***********************************************************
   // function mapping
   // ***********************************************************
   always_comb begin
      alloc    = '0;
      func_nxt = '0;
      for (int t = 0; t < NUM_TERM - 1; t++) begin
         alloc[cfg_r[t].func]    = 1'b1;
         func_nxt[cfg_r[t].func] = func_nxt[cfg_r[t].func] | term_valid[t];
      end
      alloc[FUNC_NONE]    = 1'b0;
      func_nxt[FUNC_NONE] = 1'b0;
   end
   assign func_active = func_nxt | latch_r;

   // latch on deallocation
   // the latch clears only when the code is allocated again, not when the pin drops
   always_comb begin
      latch_set = '0;
      if (cfg_wr && !cfg_is_logic && cfg_idx < 4'(NUM_TERM - 1)
          && pwdata[15:0] <= 16'(FUNC_MAX) && pwdata[5:0] != old_func
          && old_func != FUNC_NONE && term_valid[cfg_idx]) begin
         latch_set[old_func] = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_r <= '0;
      end else begin
         latch_r <= (latch_r & ~alloc) | latch_set;
      end
   end

   // duplicate check
   // terminal nine may hold no function at all
   always_comb begin
      dup = (cfg_r[NUM_TERM-1].func != FUNC_NONE);
      for (int i = 0; i < NUM_TERM - 1; i++) begin
         for (int j = i + 1; j < NUM_TERM - 1; j++) begin
            if (cfg_r[i].func == cfg_r[j].func && cfg_r[i].func != FUNC_NONE) begin
               dup = 1'b1;
            end
         end
      end
   end
   assign duplicate_allocation_fault = dup;

   // ***********************************************************
   // servo on
   // ***********************************************************
   // servo on move
   // any accepted write that moves code 1 switches servo on to the virtual input
   assign servo_move = cfg_wr && !cfg_is_logic && cfg_idx < 4'(NUM_TERM)
                       && pwdata[15:0] <= 16'(FUNC_MAX) && pwdata[5:0] != old_func
                       && (old_func == FUNC_SERVO_ON || pwdata[5:0] == FUNC_SERVO_ON);

   // only a reset, standing in for power up, clears the moved state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         moved_r <= 1'b0;
      end else if (servo_move) begin
         moved_r <= 1'b1;
      end
   end
   assign repower_required_fault = moved_r;
   assign servo_on = moved_r ? virtual_input : func_active[FUNC_SERVO_ON];

   // ***********************************************************
   // interrupt status and mask
   // ***********************************************************
   assign st_set[ST_DUP_BIT]     = dup;
   assign st_set[ST_REPOWER_BIT] = moved_r;

   // set wins over a write one to clear in the same cycle
   // a condition that lasts re-arms its status bit every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= '0;
      end else if (wr_acc && paddr == REG_STATUS) begin
         status_r <= (status_r & ~pwdata[ST_W-1:0]) | st_set;
      end else begin
         status_r <= status_r | st_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= '0;
      end else if (wr_acc && paddr == REG_MASK) begin
         mask_r <= pwdata[ST_W-1:0];
      end
   end
   assign irq = |(status_r & mask_r);

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   dup_sticky_a : assert property (dup |=> status_r[ST_DUP_BIT])
      else $error("duplicate allocation not flagged");
   latch_hold_a : assert property (latch_set != '0 |=> (func_active & $past(latch_set)) != '0)
      else $error("deallocated function not held");
   slow_filt_a : assert property ($changed(filt_r[0]) |-> $past(cnt_r[0]) == CNT_W'(SLOW_CYC - 1))
      else $error("slow filter changed early");
   fast_filt_a : assert property ($changed(filt_r[7]) |-> $past(cnt_r[7]) == CNT_W'(FAST_CYC - 1))
      else $error("fast filter changed early");
   glitch_block_a : assert property (
      $changed(input_terminal[1]) ##1 $changed(input_terminal[1]) |=> $stable(filt_r[1]))
      else $error("short pulse passed filter");
   // terminal one carries the logic select sweep, so its checks see every mode but low level
   rise_pulse_a : assert property (
      cfg_r[0].lsel == LOGIC_RISE && cfg_r[0].func != FUNC_NONE
      && !dup && $rose(filt_r[0]) |-> func_active[cfg_r[0].func])
      else $error("rising edge missed");
   fall_pulse_a : assert property (
      cfg_r[0].lsel == LOGIC_FALL && cfg_r[0].func != FUNC_NONE
      && !dup && $fell(filt_r[0]) |-> func_active[cfg_r[0].func])
      else $error("falling edge missed");
   level_high_a : assert property (
      cfg_r[0].lsel == LOGIC_HIGH && cfg_r[0].func != FUNC_NONE && !dup
      && !latch_r[cfg_r[0].func] |-> func_active[cfg_r[0].func] == filt_r[0])
      else $error("high level function wrong");
   // a falling edge setting on terminal nine rightly ignores the rise
   fly_switch_a : assert property (
      cfg_r[NUM_TERM-1].lsel != LOGIC_FALL && $rose(filt_r[8]) |-> pos_change_switch)
      else $error("terminal nine edge lost");
   edge_single_a : assert property (
      cfg_r[0].lsel == LOGIC_BOTH && term_valid[0] && $stable(cfg_r[0]) |=> !term_valid[0])
      else $error("edge pulse longer than one clock");
   servo_virt_a : assert property (
      servo_move |=> repower_required_fault && servo_on == virtual_input)
      else $error("servo on not taken from virtual input");
   repower_hold_a : assert property (repower_required_fault |=> repower_required_fault)
      else $error("repower fault dropped");
   run_lock_a : assert property (
      wr_acc && cfg_hit && drive_running |=> cfg_r[$past(cfg_idx)] == $past(cfg_r[cfg_idx]))
      else $error("setting changed while running");
   code_range_a : assert property (cfg_r[4].func <= FUNC_MAX && cfg_r[4].lsel <= LOGIC_MAX)
      else $error("setting out of range");
   irq_level_a : assert property (irq == |(status_r & mask_r))
      else $error("interrupt output wrong");
   dup_clear_a : assert property (
      wr_acc && paddr == REG_STATUS && pwdata[ST_DUP_BIT] && !dup |=> !status_r[ST_DUP_BIT])
      else $error("duplicate status not cleared");
   latch_clear_a : assert property (
      latch_r[FUNC_SERVO_ON] && alloc[FUNC_SERVO_ON] && !latch_set[FUNC_SERVO_ON]
      |=> !latch_r[FUNC_SERVO_ON])
      else $error("latched function not released");
   prdata_hold_a : assert property (!rd_setup |=> $stable(prdata))
      else $error("read data moved outside setup");

   // ***********************************************************
   // cover points
   // ***********************************************************
   dup_seen_c : cover property (dup ##1 irq);
   latch_seen_c : cover property (latch_set != '0 ##1 latch_r != '0);
   servo_move_c : cover property (servo_move ##1 servo_on);
   fly_seen_c : cover property (pos_change_switch);
   edge_seen_c : cover property (cfg_r[0].lsel == LOGIC_BOTH && term_valid[0]);
endmodule

/* File: tb_digital_input_conditioner.sv */
// self-checking bench for the digital input conditioner
module tb_digital_input_conditioner
   import dic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLOW  = 8;
   localparam int FAST  = 3;
   localparam int LIMIT = 20000;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata;
   logic [NUM_TERM-1:0] term;
   logic                drive_running, virtual_input, servo_on, pos_sw, dup_f, rep_f, irq;
   logic [NUM_FUNC-1:0] func_active;
   logic                cmd_go, cmd_lvl, cmd_pulse, busy;
   logic [3:0]          cmd_idx;
   logic [7:0]          cmd_len;
   int                  n_mismatch, n_compared, cyc;

   dic_top #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dic_top (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_terminal(term), .drive_running(drive_running), .virtual_input(virtual_input),
      .func_active(func_active), .servo_on(servo_on), .pos_change_switch(pos_sw),
      .duplicate_allocation_fault(dup_f), .repower_required_fault(rep_f), .irq(irq));
   dic_term_model #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) u_dic_term_model (
      .pclk(pclk), .presetn(presetn), .cmd_go(cmd_go), .cmd_idx(cmd_idx), .cmd_lvl(cmd_lvl),
      .cmd_pulse(cmd_pulse), .cmd_len(cmd_len), .busy(busy), .term(term));

   // ***********************************************************
   // shared tasks
   // ***********************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // entered just after a rising edge; leaves one idle edge so psel is never set twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
   endtask
   task automatic wait_idle();
      do @(posedge pclk); while (busy !== 1'b0);
   endtask
   task automatic cmd(input int idx, input logic lvl, input logic pulse, input int len);
      cmd_idx   <= 4'(idx);
      cmd_lvl   <= lvl;
      cmd_pulse <= pulse;
      cmd_len   <= 8'(len);
      cmd_go    <= 1'b1;
      @(posedge pclk);
      cmd_go    <= 1'b0;
   endtask
   function automatic logic exp_fa(input logic [2:0] ls, input logic lvl, input logic ed);
      if (ls == LOGIC_LOW) return !lvl;
      if (ls == LOGIC_HIGH) return lvl;
      if (!ed) return 1'b0;
      return (ls == LOGIC_RISE) ? lvl : (ls == LOGIC_FALL) ? !lvl : 1'b1;
   endfunction
   // f equal to NUM_FUNC watches the position change switch instead of a function bit
   function automatic logic sig(input int f);
      return (f >= NUM_FUNC) ? pos_sw : func_active[f];
   endfunction
   task automatic term_chk(input int idx, input logic lvl, input logic [2:0] ls, input int f);
      int n;
      n = (idx < NUM_SLOW) ? SLOW : FAST;
      cmd(idx, lvl, 1'b0, 0);
      repeat (n - 1) @(posedge pclk);
      #1 chk(sig(f), exp_fa(ls, !lvl, 1'b0));
      @(posedge pclk);
      #1 chk(sig(f), exp_fa(ls, lvl, 1'b1));
      @(posedge pclk);
      #1 chk(sig(f), exp_fa(ls, lvl, 1'b0));
      wait_idle();
   endtask
   task automatic pulse_chk(input int idx, input int len, input int f, input logic exp);
      cmd(idx, 1'b1, 1'b1, len);
      repeat (len + SLOW + 2) begin
         @(posedge pclk);
         #1 chk(sig(f), exp);
      end
      wait_idle();
   endtask

   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      for (int t = 0; t < NUM_TERM; t++) begin
         rd_chk(8'(8 * t), 32'(FUNC_RST[t]));
         rd_chk(8'(8 * t + 4), 32'h0);
      end
      chk(func_active[31:0], 32'h0000f00e);
      rd_chk(REG_FUNC_LO, 32'h0000f00e);
      rd_chk(REG_FUNC_HI, 32'h0);
      chk(pready, 1'b1);
      apb(1'b0, 8'h60, 32'h0, q, e);
      chk(e, 1'b1);
      chk(q, 32'h0);
      wr(8'h00, 32'h26);
      rd_chk(8'h00, 32'h0e);
      wr(8'h30, 32'h25);
      rd_chk(8'h30, 32'h25);
      wr(8'h30, 32'h03);
      wr(8'h04, 32'h5);
      rd_chk(8'h04, 32'h0);
      drive_running <= 1'b1;
      wr(8'h28, 32'h0);
      drive_running <= 1'b0;
      rd_chk(8'h28, 32'h0c);
      $display("test regs done");
   endtask
   task automatic t_logic();
      pulse_chk(0, SLOW - 1, 14, 1'b1);
      pulse_chk(1, 1, 15, 1'b1);
      pulse_chk(8, FAST - 1, NUM_FUNC, 1'b0);
      for (int ls = 0; ls <= 4; ls++) begin
         wr(8'h04, 32'(ls));
         term_chk(0, 1'b1, 3'(ls), 14);
         term_chk(0, 1'b0, 3'(ls), 14);
      end
      wr(8'h04, 32'h0);
      wr(8'h38, 32'h5);
      wr(8'h3c, 32'(LOGIC_HIGH));
      term_chk(7, 1'b1, LOGIC_HIGH, 5);
      term_chk(7, 1'b0, LOGIC_HIGH, 5);
      term_chk(8, 1'b1, LOGIC_RISE, NUM_FUNC);
      term_chk(8, 1'b0, LOGIC_RISE, NUM_FUNC);
      $display("test filter and logic done");
   endtask
   task automatic t_faults();
      wr(REG_MASK, 32'h0);
      wr(8'h38, 32'h0d);
      chk(dup_f, 1'b1);
      chk(irq, 1'b0);
      wr(REG_MASK, 32'h3);
      chk(irq, 1'b1);
      wr(8'h38, 32'h5);
      chk(dup_f, 1'b0);
      rd_chk(REG_STATUS, 32'h1);
      wr(REG_STATUS, 32'h1);
      rd_chk(REG_STATUS, 32'h0);
      chk(irq, 1'b0);
      wr(8'h40, 32'h14);
      chk(dup_f, 1'b1);
      wr(8'h40, 32'h0);
      wr(REG_STATUS, 32'h1);
      $display("test faults done");
   endtask
   task automatic t_latch();
      wr(8'h08, 32'h0);
      chk(func_active[15], 1'b1);
      cmd(1, 1'b1, 1'b0, 0);
      wait_idle();
      chk(func_active[15], 1'b1);
      rd_chk(REG_INPUTS, 32'h2);
      wr(8'h08, 32'h0f);
      // the latch drops one edge after the code returns
      @(posedge pclk);
      chk(func_active[15], 1'b0);
      cmd(1, 1'b0, 1'b0, 0);
      wait_idle();
      $display("test latch done");
   endtask
   task automatic t_servo();
      chk(servo_on, 1'b1);
      chk(rep_f, 1'b0);
      wr(8'h20, 32'h0);
      chk(rep_f, 1'b1);
      virtual_input <= 1'b1;
      @(posedge pclk);
      #1 chk(servo_on, 1'b1);
      @(posedge pclk);
      virtual_input <= 1'b0;
      @(posedge pclk);
      #1 chk(servo_on, 1'b0);
      @(posedge pclk);
      wr(8'h20, 32'h1);
      wr(REG_STATUS, 32'h2);
      rd_chk(REG_STATUS, 32'h2);
      chk(irq, 1'b1);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(rep_f, 1'b0);
      chk(servo_on, 1'b1);
      $display("test servo on done");
   endtask

   // ***********************************************************
   // clock, timeout, verdict
   // ***********************************************************
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ceiling well above the few hundred cycles the scenarios need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         print_verdict();
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, cmd_go, cmd_lvl, cmd_pulse} = '0;
      {drive_running, virtual_input, paddr, pwdata, cmd_idx, cmd_len} = '0;
      {n_mismatch, n_compared, cyc} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_logic();
      t_faults();
      t_latch();
      t_servo();
      print_verdict();
   end
endmodule
